// File: hw/mis_defines.svh
// constants for the modem initialization serial sender
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH
`define MIS_CLK_HZ             50000000
`define MIS_BAUD               9600
`define MIS_STORE_HEAD_LARGE   1000
`define MIS_STORE_LAST_LARGE   1059
`define MIS_STORE_HEAD_SMALL   200
`define MIS_STORE_LAST_SMALL   255
`define MIS_CHAR_CR            8'h0d
`define MIS_CHAR_LF            8'h0a
`define MIS_FRAME_BITS         10
`define MIS_RX_HOLD_CYCLES     2500000
`endif

// File: hw/mis_pkg.sv
// types of the modem initialization serial sender
package mis_pkg;
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_USER,
    MODE_PRESET_CH1,
    MODE_PRESET_CH2
  } mis_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SCAN,
    ST_LOAD,
    ST_SEND,
    ST_DONE,
    ST_FAIL,
    ST_OFF
  } mis_state_t;
endpackage

// File: hw/mis_sender.sv
// modem initialization serial sender: command store, scan, framing, indicators
`include "mis_defines.svh"
module mis_sender #(
  parameter int unsigned BIT_CYCLES  = `MIS_CLK_HZ / `MIS_BAUD,
  parameter int unsigned RX_HOLD     = `MIS_RX_HOLD_CYCLES,
  parameter int unsigned DEPTH_LARGE = `MIS_STORE_LAST_LARGE - `MIS_STORE_HEAD_LARGE + 1,
  parameter int unsigned DEPTH_SMALL = `MIS_STORE_LAST_SMALL - `MIS_STORE_HEAD_SMALL + 1
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              clk_en_i,
  input  wire mis_pkg::mis_mode_t init_mode_i,
  input  wire logic              port_other_proto_i,
  input  wire logic              small_model_i,
  input  wire logic              store_we_i,
  input  wire logic [5:0]        store_addr_i,
  input  wire logic [7:0]        store_data_i,
  input  wire logic              store_clr_i,
  input  wire logic              rx_i,
  output logic                   tx_o,
  output logic                   tx_led_o,
  output logic                   rx_led_o,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   init_err_o
);
  import mis_pkg::*;

  localparam int unsigned DEPTH = (DEPTH_LARGE > DEPTH_SMALL) ? DEPTH_LARGE : DEPTH_SMALL;

  logic [7:0]       mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;

  mis_state_t state, next_state;
  logic       even7, next_even7;
  logic       en, next_en;
  logic [5:0] idx, next_idx;
  logic [5:0] last, next_last;
  logic [5:0] lim, next_lim;
  logic [3:0] bitn, next_bitn;
  logic [15:0] baud, next_baud;
  logic [9:0] shreg, next_shreg;
  logic       tx_led, next_tx_led;
  logic       rx_prev, next_rx_prev;
  logic [23:0] hold, next_hold;
  logic       rx_led, next_rx_led;
  logic       busy, next_busy;
  logic       done, next_done;
  logic       err, next_err;

  // frame with start bit in bit 0, sent lsb first
  function automatic logic [9:0] mk_frame(input logic [7:0] c, input logic par7);
    if (par7)
    begin
      mk_frame = {1'b1, ^c[6:0], c[6:0], 1'b0};
    end
    else
    begin
      mk_frame = {1'b1, c, 1'b0};
    end
  endfunction

  // the port sends its string only in a stored-string mode with no other protocol
  function automatic logic link_on(input mis_mode_t m, input logic other);
    link_on = (m != MODE_NONE) && !other;
  endfunction

  // step to the next store register
  function automatic logic [5:0] step_idx(input logic [5:0] i);
    step_idx = i + 6'd1;
  endfunction

  // last clock of a bit time, last bit of a frame
  function automatic logic bit_end(input logic [15:0] b);
    bit_end = (32'(b) == BIT_CYCLES - 1);
  endfunction

  function automatic logic frame_end(input logic [3:0] n);
    frame_end = (32'(n) == `MIS_FRAME_BITS - 1);
  endfunction

  // command store, one character per register, with a set flag
  // store keeps its contents through reset; store_clr_i empties it
  always_comb
  begin
    next_vld = vld;
    if (store_clr_i)
    begin
      next_vld = '0;
    end
    else if (store_we_i && (32'(store_addr_i) < DEPTH))
    begin
      next_vld[store_addr_i] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i)
    begin
      vld <= next_vld;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && store_we_i && (32'(store_addr_i) < DEPTH))
    begin
      mem[store_addr_i] <= store_data_i;
    end
  end

  always_comb
  begin
    next_state = state;
    next_idx   = idx;
    next_last  = last;
    next_bitn  = bitn;
    next_baud  = baud;
    next_shreg = shreg;
    next_done  = done;
    next_err   = err;
    unique case (state)
      ST_IDLE:
      begin
        if (link_on(init_mode_i, port_other_proto_i))
        begin
          next_idx   = '0;
          next_state = ST_SCAN;
        end
        else
        begin
          next_state = ST_OFF;
        end
      end
      ST_SCAN:
      begin
        if (!vld[idx])
        begin
          next_state = ST_FAIL;
          next_err   = 1'b1;
        end
        else if (idx != '0 && mem[idx - 6'd1] == `MIS_CHAR_CR && mem[idx] == `MIS_CHAR_LF)
        begin
          next_last  = idx;
          next_idx   = '0;
          next_state = ST_LOAD;
        end
        else if (idx == lim - 6'd1)
        begin
          next_state = ST_FAIL;
          next_err   = 1'b1;
        end
        else
        begin
          next_idx = step_idx(idx);
        end
      end
      ST_LOAD:
      begin
        next_shreg = mk_frame(mem[idx], even7);
        next_bitn  = '0;
        next_baud  = '0;
        next_state = ST_SEND;
      end
      ST_SEND:
      begin
        if (bit_end(baud))
        begin
          next_baud  = '0;
          next_shreg = {1'b1, shreg[9:1]};
          if (frame_end(bitn))
          begin
            if (idx == last)
            begin
              next_state = ST_DONE;
              next_done  = 1'b1;
            end
            else
            begin
              next_idx   = step_idx(idx);
              next_state = ST_LOAD;
            end
          end
          else
          begin
            next_bitn = bitn + 4'd1;
          end
        end
        else
        begin
          next_baud = baud + 16'd1;
        end
      end
      ST_DONE, ST_FAIL, ST_OFF:
      begin
        next_state = state;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_tx_led = (next_state == ST_SEND) || (next_state == ST_LOAD);
    next_busy   = (next_state == ST_SCAN) || next_tx_led;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state   <= ST_IDLE;
      idx     <= '0;
      last    <= '0;
      bitn    <= '0;
      baud    <= '0;
      shreg   <= '1;
      tx_led  <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      err     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state   <= next_state;
      idx     <= next_idx;
      last    <= next_last;
      bitn    <= next_bitn;
      baud    <= next_baud;
      shreg   <= next_shreg;
      tx_led  <= next_tx_led;
      busy    <= next_busy;
      done    <= next_done;
      err     <= next_err;
    end
  end

  // mode latch: taken once, at the first enabled edge after reset
  always_comb
  begin
    next_en    = en;
    next_even7 = even7;
    next_lim   = lim;
    if (state == ST_IDLE && link_on(init_mode_i, port_other_proto_i))
    begin
      next_en    = 1'b1;
      next_even7 = (init_mode_i == MODE_USER);
      next_lim   = small_model_i ? 6'(DEPTH_SMALL) : 6'(DEPTH_LARGE);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      even7 <= 1'b0;
      en    <= 1'b0;
      lim   <= '0;
    end
    else if (clk_en_i)
    begin
      even7 <= next_even7;
      en    <= next_en;
      lim   <= next_lim;
    end
  end

  // receive indicator: hold restarts on every falling edge of the line while en is set
  always_comb
  begin
    next_rx_prev = rx_i;
    next_hold    = hold;
    if (en && rx_prev && !rx_i)
    begin
      next_hold = 24'(RX_HOLD);
    end
    else if (hold != '0)
    begin
      next_hold = hold - 24'd1;
    end
    next_rx_led = en && (next_hold != '0);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_prev <= 1'b1;
      hold    <= '0;
      rx_led  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rx_prev <= next_rx_prev;
      hold    <= next_hold;
      rx_led  <= next_rx_led;
    end
  end

  // line idles high, no control lines driven
  assign tx_o       = shreg[0];
  assign tx_led_o   = tx_led;
  assign rx_led_o   = rx_led;
  assign busy_o     = busy;
  assign done_o     = done;
  assign init_err_o = err;
endmodule

// File: test/mis_modem.sv
// behavioural modem: decodes frames, answers one character after a line feed
module mis_modem #(
  parameter int B = 4
) (
  input  wire logic               clk_i,
  input  wire mis_pkg::mis_mode_t mode_i,
  input  wire logic               tx_i,
  output logic                    rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mis_pkg::*;
  logic [7:0] got[$];
  int         bad = 0;
  logic [8:0] f;
  initial rx_o = 1'b1;
  always
  begin
    @(negedge tx_i);
    repeat (B / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      repeat (B) @(posedge clk_i);
      f[i] = tx_i;
    end
    if (mode_i == MODE_USER)
    begin
      got.push_back({1'b0, f[6:0]});
      bad += int'(f[7] !== ^f[6:0]);
    end
    else
      got.push_back(f[7:0]);
    bad += int'(f[8] !== 1'b1);
    if (got[$] == 8'h0a)
      for (int i = 0; i < 10; i++)
      begin
        repeat (B) @(posedge clk_i);
        rx_o <= 1'((10'h29e >> i) & 1);
      end
  end
endmodule

// File: test/mis_sender_props.sv
// assertion checker for the modem initialization sender
module mis_sender_props (
  input wire logic               ref_clk_i,
  input wire logic               nrst_i,
  input wire mis_pkg::mis_mode_t init_mode_i,
  input wire logic               port_other_proto_i,
  input wire logic               rx_i,
  input wire logic               tx_o,
  input wire logic               tx_led_o,
  input wire logic               rx_led_o,
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire logic               init_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mis_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire off = init_mode_i == MODE_NONE || port_other_proto_i;
  off_dark_a: assert property (off |-> tx_o && !tx_led_o && !rx_led_o && !busy_o)
    else $error("line or indicator active while disabled");
  // four cycles per bit in simulation
  bit_len_a: assert property ($fell(tx_o) |-> !tx_o [*4])
    else $error("low bit shorter than a bit time");
  done_idle_a: assert property (done_o |-> tx_o && !busy_o && !tx_led_o)
    else $error("activity after completion");
  err_quiet_a: assert property (init_err_o |-> tx_o && !tx_led_o && !done_o)
    else $error("transfer despite a bad string");
  tx_led_a: assert property (!tx_o |-> tx_led_o)
    else $error("sending with transmit indicator off");
  rx_led_a: assert property ($fell(rx_i) && !off |-> ##[1:3] rx_led_o)
    else $error("receive indicator missed");
  send_start_a: assert property ($rose(tx_led_o) |-> ##[0:2] $fell(tx_o))
    else $error("no start bit after load");
  done_hold_a: assert property (done_o |=> done_o)
    else $error("completion flag dropped");
endmodule

bind mis_sender mis_sender_props u_props (
  .ref_clk_i         (ref_clk_i),
  .nrst_i            (nrst_i),
  .init_mode_i       (init_mode_i),
  .port_other_proto_i(port_other_proto_i),
  .rx_i              (rx_i),
  .tx_o              (tx_o),
  .tx_led_o          (tx_led_o),
  .rx_led_o          (rx_led_o),
  .busy_o            (busy_o),
  .done_o            (done_o),
  .init_err_o        (init_err_o)
);

// File: test/testbench.sv
// testbench for the modem initialization sender
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mis_pkg::*;
  logic       clk;
  logic       nrst;
  logic       we;
  logic       proto;
  logic       sm;
  logic       rx;
  logic       en;
  logic       clr;
  logic [5:0] addr;
  logic [7:0] data;
  mis_mode_t  mode;
  wire        tx;
  wire        txl;
  wire        rxl;
  wire        busy;
  wire        done;
  wire        err;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cyc = 0;
  logic [7:0] q[$];
  mis_sender #(.BIT_CYCLES(4), .RX_HOLD(8)) u_dut (.ref_clk_i(clk), .nrst_i(nrst), .clk_en_i(en),
    .init_mode_i(mode), .port_other_proto_i(proto), .small_model_i(sm), .store_we_i(we),
    .store_addr_i(addr), .store_data_i(data), .store_clr_i(clr), .rx_i(rx), .tx_o(tx),
    .tx_led_o(txl), .rx_led_o(rxl), .busy_o(busy), .done_o(done), .init_err_o(err));
  mis_modem #(.B(4)) u_modem (.clk_i(clk), .mode_i(mode), .tx_i(tx), .rx_o(rx));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // e: 0 stays off, 1 sends, 2 refuses; a zero entry is left empty; fz freezes the clock enable
  // the store is cleared and written while reset is held, as it stands at power-up
  task automatic run(input mis_mode_t m, input logic p, input logic s, input logic [7:0] str[$], input int e,
                     input logic fz = 1'b0);
    int n;
    @(posedge clk);
    #1 nrst = 0;
    mode = m;
    proto = p;
    sm = s;
    clr = 1;
    u_modem.got.delete();
    @(posedge clk);
    #1 clr = 0;
    foreach (str[i])
    begin
      we = str[i] != 8'h00;
      addr = 6'(i);
      data = str[i];
      @(posedge clk);
      #1;
    end
    if (fz)
    begin
      en = 0;
      we = 1;
      addr = 6'h00;
      data = 8'h0d;
      @(posedge clk);
      #1;
    end
    we = 0;
    repeat (20) @(posedge clk);
    #1 nrst = 1;
    if (fz)
    begin
      repeat (40) @(posedge clk);
      #1 chk(busy, 0);
      en = 1;
    end
    n = 0;
    while (!(done | err) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (60) @(posedge clk);
    chk(done, e == 1);
    chk(err, e == 2);
    chk(u_modem.got.size(), e == 1 ? str.size() : 0);
    if (e == 1)
      foreach (str[i])
        chk(u_modem.got[i], m == MODE_USER ? str[i] & 8'h7f : str[i]);
    chk(u_modem.bad, 0);
    chk({txl, rxl}, 0);
    chk(busy, 0);
    $display("run mode %0d result %0d finished", m, e);
  endtask
  initial
  begin
    {we, addr, data, proto, sm, nrst} = '0;
    en = 1;
    clr = 0;
    mode = MODE_NONE;
    run(MODE_USER, 0, 0, '{8'h41, 8'h54, 8'h0d, 8'h0a}, 1);
    run(MODE_PRESET_CH1, 0, 1, '{8'hc5, 8'h0d, 8'h0a}, 1);
    run(MODE_PRESET_CH2, 0, 0, '{8'h3a, 8'h0d, 8'h0a}, 1, 1);
    run(MODE_NONE, 0, 0, '{8'h41, 8'h0d, 8'h0a}, 0);
    run(MODE_USER, 1, 0, '{8'h41, 8'h0d, 8'h0a}, 0);
    run(MODE_PRESET_CH1, 0, 0, '{8'h41, 8'h00, 8'h0d, 8'h0a}, 2);
    run(MODE_USER, 0, 0, '{8'h0d, 8'h41, 8'h0a}, 2);
    repeat (56) q.push_back(8'h41);
    q.push_back(8'h0d);
    q.push_back(8'h0a);
    run(MODE_PRESET_CH1, 0, 1, q, 2);
    run(MODE_PRESET_CH2, 0, 0, q, 1);
    final_report;
  end
endmodule
